// ===== logic/dimming_pkg.sv
`default_nettype none
package dimming_pkg;

   // ****************************************
   // Time base
   // ****************************************
   localparam int CLK_MHZ       = 125;
   localparam longint NS_PER_US = 1000;
   localparam longint NS_PER_MS = 1000000;

   // ****************************************
   // Serial pulse windows and wake latency
   // ****************************************
   localparam int T_ONE_MIN_US  = 15;
   localparam int T_ONE_MAX_US  = 45;
   localparam int T_ZERO_MIN_US = 90;
   localparam int T_ZERO_MAX_US = 120;
   localparam int T_LOAD_MIN_US = 215;
   localparam int T_WAKE_US     = 10;
   localparam int T_TIMEOUT_MS  = 120;
   // About 7 ms over 7 steps
   localparam int T_STEP_US     = 1000;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int          LEVEL_W      = 6;
   localparam logic [5:0]  LEVEL_RST    = 6'h3F;
   localparam int          ILIM_W       = 3;
   localparam logic [2:0]  ILIM_FIRST   = 3'h0;
   localparam logic [2:0]  ILIM_LAST    = 3'h7;
   localparam int          ILIM_STEP_MA = 350;
   localparam int          SYNC_LEN     = 3;

   // Least times round up, longest round down
   function automatic int cyc_ceil(input longint ns);
      return int'((ns * CLK_MHZ + 999) / 1000);
   endfunction

   function automatic int cyc_floor(input longint ns);
      return int'((ns * CLK_MHZ) / 1000);
   endfunction

   typedef struct packed {
      logic lvl;      // Filtered line level
      logic bit_ok;   // Valid data bit seen
      logic bit_val;  // Its value
      logic load;     // Commit pulse seen
   } wire_evt_t;

endpackage
`default_nettype wire

// ===== logic/serial_pulse_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module serial_pulse_decoder
#(
   parameter int CW           = 16,
   parameter int ONE_MIN_CYC  = 1875,
   parameter int ONE_MAX_CYC  = 5625,
   parameter int ZERO_MIN_CYC = 11250,
   parameter int ZERO_MAX_CYC = 15000,
   parameter int LOAD_CYC     = 26875,
   parameter int WAKE_CYC     = 1250
)
(
   input  wire logic                   clock,   // Core clock
   input  wire logic                   arst_n,  // Async reset
   input  wire logic                   line_in, // Serial pin
   input  wire logic                   asleep,  // Device in shutdown
   output var  dimming_pkg::wire_evt_t evt      // Decoded events
);
   import dimming_pkg::*;

   if (LOAD_CYC + WAKE_CYC >= (2 ** CW) - 1 || ONE_MIN_CYC < 1)
   begin : g_chk
      $error("Counter width too small for pulse windows");
   end

   logic [SYNC_LEN-1:0] s_q;
   logic [SYNC_LEN-1:0] s_d;
   logic                filt_q;
   logic                filt_d;
   logic [CW-1:0]       cnt_q;
   logic [CW-1:0]       cnt_d;
   logic                wake_q;
   logic                wake_d;
   wire_evt_t           evt_d;

   function automatic logic in_win(input int len, input int lo, input int hi);
      return (len > lo) && (len < hi);
   endfunction

   // ****************************************
   // Pulse measurement
   // ****************************************
   always_comb
   begin
      int len;
      int off;
      len    = int'(cnt_q);
      off    = wake_q ? WAKE_CYC : 0;
      s_d    = {s_q[SYNC_LEN-2:0], line_in};
      filt_d = (s_q[1] == s_q[2]) ? s_q[2] : filt_q;
      cnt_d  = cnt_q;
      wake_d = wake_q;
      evt_d  = '0;
      evt_d.lvl = filt_d;
      // falling edge starts a low pulse
      if (filt_q && !filt_d)
      begin
         cnt_d  = CW'(1);
         // First bit after sleep has wake latency
         wake_d = asleep;
      end
      else if (!filt_q && cnt_q != {CW{1'b1}})
      begin
         cnt_d = cnt_q + CW'(1);
      end
      if (!filt_q && filt_d && in_win(len, ONE_MIN_CYC + off, ONE_MAX_CYC + off))
      begin
         evt_d.bit_ok  = 1'b1;
         evt_d.bit_val = 1'b1;
      end
      else if (!filt_q && filt_d && in_win(len, ZERO_MIN_CYC + off, ZERO_MAX_CYC + off))
      begin
         evt_d.bit_ok = 1'b1;
      end
      if (!filt_q && !filt_d && len == LOAD_CYC + 1 + off)
      begin
         evt_d.load = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q    <= '1;
         filt_q <= 1'b1;
         cnt_q  <= '0;
         wake_q <= 1'b0;
         evt    <= '0;
      end
      else
      begin
         s_q    <= s_d;
         filt_q <= filt_d;
         cnt_q  <= cnt_d;
         wake_q <= wake_d;
         evt    <= evt_d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   AST_NO_BOTH: assert property (@(posedge clock) disable iff (!arst_n)
      !(evt.bit_ok && evt.load))
      else $error("Bit and load in one cycle");

   AST_SHORT_IGNORED: assert property (@(posedge clock) disable iff (!arst_n)
      (!filt_q && filt_d && int'(cnt_q) <= ONE_MIN_CYC) |=> !evt.bit_ok)
      else $error("Short pulse taken as a bit");

endmodule
`default_nettype wire

// ===== logic/dual_pulse_dimming_control.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pulse_dimming_control
   import dimming_pkg::*;
#(
   parameter int ONE_MAX_CYC  = cyc_floor(T_ONE_MAX_US * NS_PER_US),
   parameter int ZERO_MIN_CYC = cyc_ceil(T_ZERO_MIN_US * NS_PER_US),
   parameter int ZERO_MAX_CYC = cyc_floor(T_ZERO_MAX_US * NS_PER_US),
   parameter int LOAD_CYC     = cyc_ceil(T_LOAD_MIN_US * NS_PER_US),
   parameter int TIMEOUT_CYC  = cyc_floor(T_TIMEOUT_MS * NS_PER_MS),
   parameter int STEP_CYC     = cyc_floor(T_STEP_US * NS_PER_US),
   parameter int CW           = 16,
   parameter int TMO_W        = 24,
   parameter int STEP_W       = 17
)
(
   input  wire logic                      clock,           // 125 MHz
   input  wire logic                      arst_n,          // Async reset
   input  wire logic                      serial_a_in,     // Serial dim, group A
   input  wire logic                      serial_b_in,     // Serial dim, group B
   input  wire logic                      group_a_pwm_in,  // PWM, group A
   input  wire logic                      group_b_pwm_in,  // PWM, group B
   input  wire logic                      sw_cycle_start,  // Boost cycle start
   input  wire logic                      sw_over_limit,   // Current comparator
   output var  logic [LEVEL_W-1:0]        group_a_level,   // DAC code, group A
   output var  logic [LEVEL_W-1:0]        group_b_level,   // DAC code, group B
   output var  logic                      group_a_sink_en, // Sinks on, group A
   output var  logic                      group_b_sink_en, // Sinks on, group B
   output var  logic                      boost_en,        // Boost enabled
   output var  logic [ILIM_W-1:0]         ilim_code,       // Limit step
   output var  logic                      sw_gate,         // Boost switch on
   output var  logic                      shutdown         // Low-power state
);
   import dimming_pkg::*;

   localparam int ONE_MIN_CYC = cyc_ceil(T_ONE_MIN_US * NS_PER_US);
   localparam int WAKE_CYC    = cyc_ceil(T_WAKE_US * NS_PER_US);

   if (TIMEOUT_CYC >= 2 ** TMO_W || STEP_CYC >= 2 ** STEP_W || STEP_CYC < 1)
   begin : g_chk
      $error("Timer widths too small");
   end

   typedef enum logic [1:0] {SS_OFF, SS_RAMP, SS_DONE} ss_t;

   wire_evt_t             ev_a;
   wire_evt_t             ev_b;
   logic [SYNC_LEN-1:0]   sy_q [3];
   logic [SYNC_LEN-1:0]   sy_d [3];
   logic [2:0]            flt_q;
   logic [2:0]            flt_d;
   logic [LEVEL_W-1:0]    sh_a_q;
   logic [LEVEL_W-1:0]    sh_a_d;
   logic [LEVEL_W-1:0]    sh_b_q;
   logic [LEVEL_W-1:0]    sh_b_d;
   logic [LEVEL_W-1:0]    lv_a_d;
   logic [LEVEL_W-1:0]    lv_b_d;
   logic [TMO_W-1:0]      tmo_q;
   logic [TMO_W-1:0]      tmo_d;
   logic                  sd_d;
   ss_t                   ss_q;
   ss_t                   ss_d;
   logic [STEP_W-1:0]     stp_q;
   logic [STEP_W-1:0]     stp_d;
   logic [ILIM_W-1:0]     il_d;
   logic                  sa_d;
   logic                  sb_d;
   logic                  be_d;
   logic                  gt_d;
   logic                  pwm_any;

   // ****************************************
   // Serial decoders
   // ****************************************
   // line A feeds group A
   serial_pulse_decoder #(
      .CW           (CW),
      .ONE_MIN_CYC  (ONE_MIN_CYC),
      .ONE_MAX_CYC  (ONE_MAX_CYC),
      .ZERO_MIN_CYC (ZERO_MIN_CYC),
      .ZERO_MAX_CYC (ZERO_MAX_CYC),
      .LOAD_CYC     (LOAD_CYC),
      .WAKE_CYC     (WAKE_CYC)
   ) u_dec_a (
      .clock   (clock),
      .arst_n  (arst_n),
      .line_in (serial_a_in),
      .asleep  (shutdown),
      .evt     (ev_a)
   );

   serial_pulse_decoder #(
      .CW           (CW),
      .ONE_MIN_CYC  (ONE_MIN_CYC),
      .ONE_MAX_CYC  (ONE_MAX_CYC),
      .ZERO_MIN_CYC (ZERO_MIN_CYC),
      .ZERO_MAX_CYC (ZERO_MAX_CYC),
      .LOAD_CYC     (LOAD_CYC),
      .WAKE_CYC     (WAKE_CYC)
   ) u_dec_b (
      .clock   (clock),
      .arst_n  (arst_n),
      .line_in (serial_b_in),
      .asleep  (shutdown),
      .evt     (ev_b)
   );

   // ****************************************
   // Pin synchronisers: pwm a, pwm b, over-limit
   // ****************************************
   always_comb
   begin
      logic [2:0] pins;
      pins = {sw_over_limit, group_b_pwm_in, group_a_pwm_in};
      for (int i = 0; i < 3; i++)
      begin
         sy_d[i]  = {sy_q[i][SYNC_LEN-2:0], pins[i]};
         flt_d[i] = (sy_q[i][1] == sy_q[i][2]) ? sy_q[i][2] : flt_q[i];
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 3; i++)
         begin
            sy_q[i] <= '0;
         end
         flt_q <= '0;
      end
      else
      begin
         sy_q  <= sy_d;
         flt_q <= flt_d;
      end
   end

   // ****************************************
   // Shift and brightness registers
   // ****************************************
   always_comb
   begin
      sh_a_d = sh_a_q;
      sh_b_d = sh_b_q;
      lv_a_d = group_a_level;
      lv_b_d = group_b_level;
      if (ev_a.bit_ok)
      begin
         sh_a_d = {sh_a_q[LEVEL_W-2:0], ev_a.bit_val};
      end
      if (ev_b.bit_ok)
      begin
         sh_b_d = {sh_b_q[LEVEL_W-2:0], ev_b.bit_val};
      end
      if (ev_a.load)
      begin
         lv_a_d = sh_a_q;
      end
      if (ev_b.load)
      begin
         lv_b_d = sh_b_q;
      end
   end

   // full scale, code N drives the DAC
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sh_a_q        <= LEVEL_RST;
         sh_b_q        <= LEVEL_RST;
         group_a_level <= LEVEL_RST;
         group_b_level <= LEVEL_RST;
      end
      else
      begin
         sh_a_q        <= sh_a_d;
         sh_b_q        <= sh_b_d;
         group_a_level <= lv_a_d;
         group_b_level <= lv_b_d;
      end
   end

   // ****************************************
   // Idle timeout and shutdown
   // ****************************************
   always_comb
   begin
      tmo_d = '0;
      sd_d  = shutdown;
      // both lines low for the timeout
      if (!ev_a.lvl && !ev_b.lvl && !shutdown)
      begin
         tmo_d = tmo_q + TMO_W'(1);
         if (int'(tmo_q) == TIMEOUT_CYC - 1)
         begin
            sd_d  = 1'b1;
            tmo_d = '0;
         end
      end
      // Wake only on a measured transmission
      if (ev_a.bit_ok || ev_a.load || ev_b.bit_ok || ev_b.load)
      begin
         sd_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tmo_q    <= '0;
         shutdown <= 1'b0;
      end
      else
      begin
         tmo_q    <= tmo_d;
         shutdown <= sd_d;
      end
   end

   // ****************************************
   // Soft start, sinks and switch gate
   // ****************************************
   // Duty-gated ramp timer stretches steps at low PWM duty
   assign pwm_any = flt_q[0] || flt_q[1];

   always_comb
   begin
      ss_d = ss_q;
      stp_d = stp_q;
      il_d = ilim_code;
      case (ss_q)
         SS_OFF:
         begin
            stp_d = '0;
            il_d  = ILIM_FIRST;
            if (!shutdown)
            begin
               ss_d = SS_RAMP;
            end
         end
         SS_RAMP:
         begin
            if (pwm_any)
            begin
               stp_d = stp_q + STEP_W'(1);
            end
            // one 350 mA step per interval
            if (pwm_any && int'(stp_q) == STEP_CYC - 1)
            begin
               stp_d = '0;
               il_d  = ilim_code + ILIM_W'(1);
               if (il_d == ILIM_LAST)
               begin
                  ss_d = SS_DONE;
               end
            end
         end
         SS_DONE:
         begin
            stp_d = '0;
         end
         default:
         begin
            ss_d = SS_OFF;
         end
      endcase
      // Restart the ramp after every wake
      if (shutdown)
      begin
         ss_d  = SS_OFF;
         il_d  = ILIM_FIRST;
         stp_d = '0;
      end
      sa_d = flt_d[0] && !sd_d;
      sb_d = flt_d[1] && !sd_d;
      be_d = !sd_d;
      gt_d = sw_gate;
      if (sw_cycle_start)
      begin
         gt_d = 1'b1;
      end
      if (flt_d[2] || sd_d)
      begin
         gt_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ss_q            <= SS_OFF;
         stp_q           <= '0;
         ilim_code       <= ILIM_FIRST;
         group_a_sink_en <= 1'b0;
         group_b_sink_en <= 1'b0;
         boost_en        <= 1'b0;
         sw_gate         <= 1'b0;
      end
      else
      begin
         ss_q            <= ss_d;
         stp_q           <= stp_d;
         ilim_code       <= il_d;
         group_a_sink_en <= sa_d;
         group_b_sink_en <= sb_d;
         boost_en        <= be_d;
         sw_gate         <= gt_d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic seen_a_q;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         seen_a_q <= 1'b0;
      end
      else if (ev_a.load)
      begin
         seen_a_q <= 1'b1;
      end
   end

   AST_TIMEOUT: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(shutdown) |-> $past(!ev_a.lvl && !ev_b.lvl) && int'($past(tmo_q)) == TIMEOUT_CYC - 1)
      else $error("Shutdown without full idle timeout");

   AST_SD_OFF: assert property (@(posedge clock) disable iff (!arst_n)
      shutdown |-> !boost_en && !group_a_sink_en && !group_b_sink_en && !sw_gate)
      else $error("Drivers active in shutdown");

   AST_HOLD_A: assert property (@(posedge clock) disable iff (!arst_n)
      !ev_a.load |=> $stable(group_a_level))
      else $error("Group A level moved without commit");

   AST_LOAD_B: assert property (@(posedge clock) disable iff (!arst_n)
      ev_b.load && !ev_a.load |=> group_b_level == $past(sh_b_q) && $stable(group_a_level))
      else $error("Group B commit wrong or leaked");

   AST_SHIFT_A: assert property (@(posedge clock) disable iff (!arst_n)
      ev_a.bit_ok |=> sh_a_q == {$past(sh_a_q[LEVEL_W-2:0]), $past(ev_a.bit_val)})
      else $error("Shift order wrong");

   AST_RESET_LVL: assert property (@(posedge clock) disable iff (!arst_n)
      !seen_a_q |-> group_a_level == LEVEL_RST)
      else $error("Level not full scale before first commit");

   AST_PWM_A: assert property (@(posedge clock) disable iff (!arst_n)
      (flt_q[0] && !shutdown)[*2] |-> group_a_sink_en)
      else $error("Sinks not following PWM");

   AST_ILIM_STEP: assert property (@(posedge clock) disable iff (!arst_n)
      $changed(ilim_code) && ilim_code != ILIM_FIRST |-> ilim_code == $past(ilim_code) + ILIM_W'(1))
      else $error("Limit skipped a step");

   AST_STALL: assert property (@(posedge clock) disable iff (!arst_n)
      ss_q == SS_RAMP && !pwm_any && !shutdown |=> $stable(ilim_code))
      else $error("Ramp advanced with PWM off");

   AST_OVER: assert property (@(posedge clock) disable iff (!arst_n)
      flt_q[2] |-> !sw_gate)
      else $error("Switch on above limit");

   COV_LOAD_A: cover property (@(posedge clock) disable iff (!arst_n) ev_a.load);
   COV_SD: cover property (@(posedge clock) disable iff (!arst_n) $rose(shutdown));
   COV_WAKE: cover property (@(posedge clock) disable iff (!arst_n) $fell(shutdown));
   COV_RAMP: cover property (@(posedge clock) disable iff (!arst_n) ss_q == SS_DONE);

endmodule
`default_nettype wire

// ===== tb/host_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_line_model
#(
   parameter int ONE_CYC  = 3500,
   parameter int ZERO_CYC = 7300,
   parameter int LOAD_CYC = 7700,
   parameter int GAP_CYC  = 400
)
(
   input  wire logic clock, // Core clock
   output var  logic line   // Line level after pull-up
);
   initial line = 1'b1;

   // ****************************************
   // Pulse shaping
   // ****************************************
   // low pulse, high gap
   task automatic pulse(input int low_cyc);
      @(posedge clock);
      line <= 1'b0;
      repeat (low_cyc) @(posedge clock);
      // Released line returns to the pull-up level
      line <= 1'b1;
      repeat (GAP_CYC) @(posedge clock);
   endtask

   task automatic send_bits(input logic [5:0] v);
      for (int i = 5; i >= 0; i--)
         pulse(v[i] ? ONE_CYC : ZERO_CYC);
   endtask

   task automatic send_word(input logic [5:0] v);
      send_bits(v);
      pulse(LOAD_CYC);
   endtask
endmodule
`default_nettype wire

// ===== tb/dual_pulse_dimming_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_pulse_dimming_control_bench;
   import dimming_pkg::*;

   // ****************************************
   // Shortened windows, one window at full width
   // ****************************************
   localparam int ZERO_MIN = 6000;
   localparam int ZERO_MAX = 7500;
   localparam int LOAD     = 7600;
   localparam int TMO      = 9000;
   localparam int STEP     = 50;
   localparam int LIMIT    = 130000;

   logic               clock;
   logic               arst_n;
   logic               ser_a;
   logic               ser_b;
   logic               pwm_a;
   logic               pwm_b;
   logic               cyc_start;
   logic               over_lim;
   logic [LEVEL_W-1:0] level_a;
   logic [LEVEL_W-1:0] level_b;
   logic               sink_a;
   logic               sink_b;
   logic               boost_en;
   logic [ILIM_W-1:0]  ilim;
   logic               sw_gate;
   logic               shutdown;
   int                 err_count;
   int                 checks_done;
   int                 cycles;

   dual_pulse_dimming_control #(.ZERO_MIN_CYC(ZERO_MIN), .ZERO_MAX_CYC(ZERO_MAX),
      .LOAD_CYC(LOAD), .TIMEOUT_CYC(TMO), .STEP_CYC(STEP)) u_dut (
      .clock(clock), .arst_n(arst_n), .serial_a_in(ser_a), .serial_b_in(ser_b),
      .group_a_pwm_in(pwm_a), .group_b_pwm_in(pwm_b), .sw_cycle_start(cyc_start),
      .sw_over_limit(over_lim), .group_a_level(level_a), .group_b_level(level_b),
      .group_a_sink_en(sink_a), .group_b_sink_en(sink_b), .boost_en(boost_en),
      .ilim_code(ilim), .sw_gate(sw_gate), .shutdown(shutdown));

   host_line_model u_host_a (.clock(clock), .line(ser_a));
   host_line_model u_host_b (.clock(clock), .line(ser_b));

   initial clock = 1'b0;
   always #4 clock = ~clock;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         err_count++;
         close_out();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      repeat (5) @(posedge clock);
      #1;
      chk("level_a", 8'h3F, {2'b00, level_a});
      chk("level_b", 8'h3F, {2'b00, level_b});
      chk("shutdown", 8'h00, {7'h00, shutdown});
      @(posedge clock);
      arst_n <= 1'b1;
      cyc(2);
      chk("boost_en", 8'h01, {7'h00, boost_en});
      chk("ilim", 8'h00, {5'h00, ilim});
   endtask

   task automatic t_both_lines();
      fork
         begin
            u_host_a.send_bits(6'b10_0101);
            t_bad_pulses();
         end
         u_host_b.send_word(6'b01_1010);
      join
      chk("level_a", 8'h25, {2'b00, level_a});
      chk("level_b", 8'h1A, {2'b00, level_b});
      chk("ilim paused", 8'h00, {5'h00, ilim});
   endtask

   // Stray pulses land between the bits and the commit
   task automatic t_bad_pulses();
      u_host_a.pulse(300);
      u_host_a.pulse(5800);
      u_host_a.pulse(7550);
      u_host_a.pulse(LOAD + 100);
      chk("level_a", 8'h25, {2'b00, level_a});
   endtask

   task automatic t_pwm_ramp();
      @(posedge clock);
      pwm_a <= 1'b1;
      cyc(6);
      chk("sink_a", 8'h01, {7'h00, sink_a});
      chk("sink_b", 8'h00, {7'h00, sink_b});
      cyc(3 * STEP);
      chk("ilim", 8'h03, {5'h00, ilim});
      pwm_a <= 1'b0;
      cyc(6);
      chk("sink_a", 8'h00, {7'h00, sink_a});
      chk("level_a", 8'h25, {2'b00, level_a});
      cyc(4 * STEP);
      chk("ilim held", 8'h03, {5'h00, ilim});
      pwm_b <= 1'b1;
      cyc(6);
      chk("sink_b", 8'h01, {7'h00, sink_b});
      cyc(5 * STEP);
      chk("ilim top", 8'h07, {5'h00, ilim});
      pwm_b <= 1'b0;
      cyc(6);
   endtask

   task automatic t_switch();
      @(posedge clock);
      cyc_start <= 1'b1;
      @(posedge clock);
      cyc_start <= 1'b0;
      cyc(3);
      chk("sw_gate on", 8'h01, {7'h00, sw_gate});
      over_lim <= 1'b1;
      cyc(5);
      chk("sw_gate off", 8'h00, {7'h00, sw_gate});
      cyc_start <= 1'b1;
      cyc(1);
      cyc_start <= 1'b0;
      cyc(3);
      chk("sw_gate held", 8'h00, {7'h00, sw_gate});
      over_lim <= 1'b0;
      cyc(1);
   endtask

   task automatic t_sleep_wake();
      pwm_a <= 1'b1;
      fork
         u_host_a.pulse(TMO + 100);
         u_host_b.pulse(TMO + 100);
         begin
            cyc(TMO + 60);
            chk("shutdown", 8'h01, {7'h00, shutdown});
            chk("boost_en", 8'h00, {7'h00, boost_en});
            chk("sink_a", 8'h00, {7'h00, sink_a});
         end
      join
      pwm_a <= 1'b0;
      chk("idle shutdown", 8'h01, {7'h00, shutdown});
      chk("level_a", 8'h25, {2'b00, level_a});
      chk("level_b", 8'h1A, {2'b00, level_b});
      u_host_b.send_word(6'b01_1111);
      chk("shutdown", 8'h00, {7'h00, shutdown});
      chk("boost_en", 8'h01, {7'h00, boost_en});
      chk("level_b", 8'h1F, {2'b00, level_b});
      chk("level_a", 8'h25, {2'b00, level_a});
      chk("ilim", 8'h00, {5'h00, ilim});
   endtask

   initial
   begin
      arst_n = 1'b0;
      pwm_a = 1'b0;
      pwm_b = 1'b0;
      cyc_start = 1'b0;
      over_lim = 1'b0;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      t_reset();
      t_both_lines();
      t_pwm_ramp();
      t_switch();
      t_sleep_wake();
      close_out();
   end
endmodule
`default_nettype wire
